// File: src/idle_powerdown_reset_control.sv
// Purpose: Idle and power-down control with reset source sequencing
// Assumes: irq_req_i is the controller's enabled, pending interrupt request
// Notes:   Clock enables are outputs; the clock tree gates on them
//
// Decided for this implementation: the register addresses and the strobed register port.
module idle_powerdown_reset_control
    import pwr_rst_pkg::*;
#(
    parameter int WDT_BITS  = 17,
    parameter int POR_DELAY = pwr_rst_pkg::POR_DELAY_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    input  wire logic       reset_pin_i,
    input  wire logic       int0_n_i,
    input  wire logic       int1_n_i,
    input  wire logic       ext_prog_i,
    input  wire logic       irq_req_i,
    input  wire logic       ale_cpu_i,
    input  wire logic       prog_store_strobe_cpu_i,
    input  wire logic [7:0] port0_reg_i,
    input  wire logic [7:0] port2_reg_i,
    input  wire logic [7:0] bus_lo_i,
    input  wire logic       bus_lo_oe_i,
    input  wire logic [7:0] addr_hi_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       we_i,
    input  wire logic       re_i,
    output logic      [7:0] rdata_o,
    output logic            cpu_clk_en_o,
    output logic            periph_clk_en_o,
    output logic            cpu_reset_o,
    output logic            ale_o,
    output logic            program_store_strobe_o,
    output logic      [7:0] port0_o,
    output logic            port0_oe_o,
    output logic      [7:0] port2_o
);
    import pwr_rst_pkg::*;

    typedef enum logic [2:0] {
        ST_POR  = 3'b000,
        ST_RUN  = 3'b001,
        ST_EXT  = 3'b011,
        ST_HOLD = 3'b010,
        ST_WDT  = 3'b110
    } rst_state_t;

    if (WDT_BITS < 4 || POR_DELAY < 1 || POR_DELAY > 65535) begin : g_chk
        $error("idle_powerdown_reset_control parameters out of range");
    end

    logic        rst_meta_q;
    logic        rst_sync_q;
    logic        pin_rst;
    logic        int0_n;
    logic        int1_n;
    logic        ext_prog_s;
    logic        ext_prog_q;
    logic [1:0]  phase_q;
    logic        rst_seen_q;
    rst_state_t  state_q;
    rst_state_t  state_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        in_reset;
    logic        idle_q;
    logic        pd_q;
    logic [7:0]  wd_q;
    logic [7:0]  icfg_q;
    logic        wdt_timeout;
    logic        wdt_reset;
    logic        ex_level_wake;
    logic        idle_wake;
    logic        wr_pwrc;
    logic        wr_wd;
    logic        wr_icfg;
    logic        rwt_hit;
    logic [7:0]  idle_p0_q;
    logic [7:0]  idle_p2_q;

    // Power-on reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else if (clk_en_i) begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Pins pass two flops before any logic
    sync2 #(.WIDTH(1), .INIT(1'b1)) u_sync_rst (
        .clk_i   (clk_i),
        .rst_n_i (rst_sync_q),
        .ce_i    (clk_en_i),
        .d_i     (reset_pin_i),
        .q_o     (pin_rst)
    );

    sync2 #(.WIDTH(3), .INIT(1'b1)) u_sync_pins (
        .clk_i   (clk_i),
        .rst_n_i (rst_sync_q),
        .ce_i    (clk_en_i),
        .d_i     ({int0_n_i, int1_n_i, ext_prog_i}),
        .q_o     ({int0_n, int1_n, ext_prog_s})
    );

    // Program-memory strap caught while the sequencer still holds reset
    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ext_prog_q <= 1'b0;
        end else if (clk_en_i && in_reset) begin
            ext_prog_q <= ext_prog_s;
        end
    end

    // Machine cycle state counter; frozen while all clocks are stopped
    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            phase_q <= 2'h0;
        end else if (clk_en_i && !pd_q) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // Reset pin sample in the fourth state; every clock during power-down
    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rst_seen_q <= 1'b0;
        end else if (clk_en_i) begin
            if (pd_q) begin
                rst_seen_q <= pin_rst;
            end else if (phase_q == FOURTH_STATE) begin
                rst_seen_q <= pin_rst;
            end
        end
    end

    assign in_reset = (state_q != ST_RUN);

    // Reset source sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_POR: begin
                if (cnt_q == 16'(POR_DELAY - 1)) begin
                    state_d = ST_RUN;
                    cnt_d   = 16'h0000;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            ST_RUN: begin
                cnt_d = 16'h0000;
                if (rst_seen_q) begin
                    state_d = ST_EXT;
                end else if (wdt_reset) begin
                    state_d = ST_WDT;
                end
            end
            ST_EXT: begin
                cnt_d = 16'h0000;
                if (!rst_seen_q) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (rst_seen_q) begin
                    state_d = ST_EXT;
                    cnt_d   = 16'h0000;
                end else if (cnt_q == 16'(RST_HOLD_CYC - 1)) begin
                    state_d = ST_RUN;
                    cnt_d   = 16'h0000;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            ST_WDT: begin
                if (cnt_q == 16'(RST_HOLD_CYC - 1)) begin
                    state_d = ST_RUN;
                    cnt_d   = 16'h0000;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            default: begin
                state_d = ST_POR;
                cnt_d   = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= ST_POR;
            cnt_q   <= 16'h0000;
        end else if (clk_en_i) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Register write decode
    always_comb begin
        wr_pwrc = 1'b0;
        wr_wd   = 1'b0;
        wr_icfg = 1'b0;
        if (we_i && addr_i == ADDR_PWRC) begin
            wr_pwrc = 1'b1;
        end else if (we_i && addr_i == ADDR_WDCTL) begin
            wr_wd = 1'b1;
        end else if (we_i && addr_i == ADDR_INTCFG) begin
            wr_icfg = 1'b1;
        end
    end

    assign rwt_hit = wr_wd && wdata_i[WD_RWT];

    // Low level on an enabled, level-mode pin with global enable set
    assign ex_level_wake = icfg_q[IC_GLOBAL] &&
        ((!int0_n && icfg_q[IC_EX0_EN] && !icfg_q[IC_EX0_EDGE]) ||
         (!int1_n && icfg_q[IC_EX1_EN] && !icfg_q[IC_EX1_EDGE]));

    assign idle_wake = irq_req_i || ex_level_wake ||
        (wd_q[WD_WDIF] && icfg_q[IC_WDT_EN] && icfg_q[IC_GLOBAL]);

    // Idle and power-down request bits
    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            idle_q <= 1'b0;
            pd_q   <= 1'b0;
        end else if (clk_en_i) begin
            if (in_reset || rst_seen_q) begin
                idle_q <= 1'b0;
                pd_q   <= 1'b0;
            end else if (pd_q) begin
                if (ex_level_wake) begin
                    pd_q <= 1'b0;
                end
            end else if (idle_q) begin
                if (idle_wake) begin
                    idle_q <= 1'b0;
                end
            end else if (wr_pwrc) begin
                idle_q <= wdata_i[PWRC_IDLE];
                pd_q   <= wdata_i[PWRC_PD];
            end
        end
    end

    // Interrupt configuration; cleared by every reset
    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            icfg_q <= IC_RESET;
        end else if (clk_en_i) begin
            if (in_reset) begin
                icfg_q <= IC_RESET;
            end else if (wr_icfg) begin
                icfg_q <= wdata_i;
            end
        end
    end

    // Watchdog runs with the peripheral clock only
    wdt_core #(.TIMEOUT_BITS(WDT_BITS), .RESET_DELAY(WDT_RST_DELAY)) u_wdt (
        .clk_i       (clk_i),
        .rst_n_i     (rst_sync_q),
        .ce_i        (clk_en_i && !pd_q && !in_reset),
        .clear_i     (clk_en_i && in_reset),
        .restart_i   (clk_en_i && rwt_hit),
        .rst_en_i    (wd_q[WD_EWT]),
        .timeout_o   (wdt_timeout),
        .reset_req_o (wdt_reset)
    );

    // Watchdog control; hardware sets win over software clears
    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wd_q <= WD_POR_VALUE;
        end else if (clk_en_i) begin
            if (state_q == ST_RUN && state_d == ST_WDT) begin
                wd_q[WD_WRST] <= 1'b1;
                wd_q[WD_WDIF] <= 1'b0;
                wd_q[WD_RWT]  <= 1'b0;
            end else if (in_reset) begin
                wd_q[WD_WDIF] <= 1'b0;
                wd_q[WD_RWT]  <= 1'b0;
            end else begin
                if (wr_wd) begin
                    wd_q[WD_POR]  <= wdata_i[WD_POR];
                    wd_q[WD_WRST] <= wdata_i[WD_WRST];
                    wd_q[WD_EWT]  <= wdata_i[WD_EWT];
                    wd_q[WD_WDIF] <= wdata_i[WD_WDIF];
                end
                if (wdt_timeout) begin
                    wd_q[WD_WDIF] <= 1'b1;
                end
                wd_q[WD_RWT] <= 1'b0;
            end
        end
    end

    // Read port; data stand in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            rdata_o <= 8'h00;
            if (re_i && addr_i == ADDR_PWRC) begin
                rdata_o <= {6'h00, pd_q, idle_q};
            end else if (re_i && addr_i == ADDR_WDCTL) begin
                rdata_o <= wd_q | WD_ONES;
            end else if (re_i && addr_i == ADDR_INTCFG) begin
                rdata_o <= icfg_q;
            end else if (re_i && addr_i == ADDR_STATUS) begin
                rdata_o <= {3'h0, ext_prog_q, state_q, in_reset};
            end
        end
    end

    // Port levels captured at idle entry
    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            idle_p0_q <= 8'hFF;
            idle_p2_q <= 8'hFF;
        end else if (clk_en_i && !idle_q) begin
            idle_p0_q <= ext_prog_q ? bus_lo_i : port0_reg_i;
            idle_p2_q <= ext_prog_q ? addr_hi_i : port2_reg_i;
        end
    end

    // Clock enables and reset to the core
    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            cpu_clk_en_o    <= 1'b1;
            periph_clk_en_o <= 1'b1;
            cpu_reset_o     <= 1'b1;
        end else if (clk_en_i) begin
            cpu_clk_en_o    <= !idle_q && !pd_q;
            periph_clk_en_o <= !pd_q;
            cpu_reset_o     <= in_reset || rst_seen_q;
        end
    end

    // Strobes and ports by mode
    always_ff @(posedge clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ale_o                  <= 1'b1;
            program_store_strobe_o <= 1'b1;
            port0_o                <= 8'hFF;
            port0_oe_o             <= 1'b0;
            port2_o                <= 8'hFF;
        end else if (clk_en_i) begin
            if (pd_q) begin
                ale_o                  <= 1'b0;
                program_store_strobe_o <= 1'b0;
                port0_o                <= port0_reg_i;
                port0_oe_o             <= !ext_prog_q;
                port2_o                <= port2_reg_i;
            end else if (idle_q) begin
                ale_o                  <= 1'b1;
                program_store_strobe_o <= 1'b1;
                port0_o                <= idle_p0_q;
                port0_oe_o             <= !ext_prog_q;
                port2_o                <= ext_prog_q ? addr_hi_i : idle_p2_q;
            end else if (ext_prog_q) begin
                ale_o                  <= ale_cpu_i;
                program_store_strobe_o <= prog_store_strobe_cpu_i;
                port0_o                <= bus_lo_i;
                port0_oe_o             <= bus_lo_oe_i;
                port2_o                <= addr_hi_i;
            end else begin
                ale_o                  <= ale_cpu_i;
                program_store_strobe_o <= prog_store_strobe_cpu_i;
                port0_o                <= port0_reg_i;
                port0_oe_o             <= 1'b1;
                port2_o                <= port2_reg_i;
            end
        end
    end
endmodule : idle_powerdown_reset_control

// File: src/pwr_rst_pkg.sv
// Purpose: Shared constants for idle, power-down and reset sequencing
// Assumes: 250 MHz system clock, four clock states per machine cycle
// Notes:   Register offsets are byte addresses on the plain register port
// Functional notes
// - Writing the idle bit makes that write last, then idle begins
// - Idle stops only the CPU clock; peripheral clocks and CPU state kept
// - Idle drives both strobes high; ports keep levels from idle entry
// - Enabled interrupt ends idle, hardware clears idle bit, program resumes
// - Idle ended by reset never runs the following instruction
// - Watchdog runs in idle; timeout wakes, reset follows 512 clocks later
// - Writing the power-down bit makes that write last, then clocks stop
// - Power-down drives both strobes low; ports show their port registers
// - High reset pin ends power-down, restarts clock, restarts at zero
// - Watchdog cannot produce a reset during power-down
// - Low enabled level-mode interrupt pin with global enable ends power-down
// - External program memory: port 0 floats; port 2 address idle, data down
// - Reset pin sampled in fourth state of each machine cycle, applied synchronously
// - Reset held while pin high and two machine cycles after release
// - External reset sets no flag; both cause flags clear mean external
// - Supply loss resets; recovery applies delay and sets power-on flag
// - Most bits take fixed reset values; cause flags depend on source
// - Watchdog control register reset values depend on reset source
// - Watchdog reset held two machine cycles, then execution from zero
package pwr_rst_pkg;
    localparam int        CLK_PERIOD_NS  = 4;
    localparam int        STATES_PER_MC  = 4;
    localparam logic [1:0] FOURTH_STATE  = 2'h3;
    localparam int        RST_HOLD_MC    = 2;
    localparam int        RST_HOLD_CYC   = RST_HOLD_MC * STATES_PER_MC;
    localparam int        WDT_RST_DELAY  = 512;
    localparam int        POR_DELAY_CYC  = 64;
    // Register byte addresses
    localparam logic [7:0] ADDR_PWRC     = 8'h00;
    localparam logic [7:0] ADDR_WDCTL    = 8'h04;
    localparam logic [7:0] ADDR_INTCFG   = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;
    // Power control fields
    localparam int        PWRC_IDLE      = 0;
    localparam int        PWRC_PD        = 1;
    // Watchdog control fields
    localparam int        WD_RWT         = 0;
    localparam int        WD_EWT         = 1;
    localparam int        WD_WRST        = 2;
    localparam int        WD_WDIF        = 3;
    localparam int        WD_POR         = 6;
    localparam logic [7:0] WD_ONES       = 8'h30;
    localparam logic [7:0] WD_POR_VALUE  = 8'h40;
    // Interrupt configuration fields
    localparam int        IC_EX0_EN      = 0;
    localparam int        IC_EX1_EN      = 1;
    localparam int        IC_EX0_EDGE    = 2;
    localparam int        IC_EX1_EDGE    = 3;
    localparam int        IC_WDT_EN      = 4;
    localparam int        IC_GLOBAL      = 7;
    localparam logic [7:0] IC_RESET      = 8'h00;
endpackage : pwr_rst_pkg

// File: src/sync2.sv
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs are slow levels from outside the clock domain
// Notes:   First stage feeds only the second stage
module sync2 #(
    parameter int        WIDTH = 1,
    parameter logic      INIT  = 1'b0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_chk
        $error("sync2 width must be at least one");
    end

    // Two stages, the first read by nothing else
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= {WIDTH{INIT}};
            q_o    <= {WIDTH{INIT}};
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : sync2

// File: src/wdt_core.sv
// Purpose: Free running watchdog with timeout and delayed reset request
// Assumes: ce_i low freezes the count, as when peripheral clocks stop
// Notes:   Restart clears both the interval and the pending reset delay
module wdt_core #(
    parameter int TIMEOUT_BITS = 17,
    parameter int RESET_DELAY  = 512
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic clear_i,
    input  wire logic restart_i,
    input  wire logic rst_en_i,
    output logic      timeout_o,
    output logic      reset_req_o
);
    logic [TIMEOUT_BITS-1:0] cnt_q;
    logic [9:0]              dly_q;
    logic                    armed_q;

    if (TIMEOUT_BITS < 4 || RESET_DELAY < 1 || RESET_DELAY > 1023) begin : g_chk
        $error("wdt_core parameters out of range");
    end

    // Interval counter; timeout pulses when it wraps
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q     <= '0;
            timeout_o <= 1'b0;
        end else if (clear_i || restart_i) begin
            cnt_q     <= '0;
            timeout_o <= 1'b0;
        end else if (ce_i) begin
            cnt_q     <= cnt_q + 1'b1;
            timeout_o <= &cnt_q;
        end else begin
            timeout_o <= 1'b0;
        end
    end

    // Delay from timeout to reset request
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_q     <= 1'b0;
            dly_q       <= '0;
            reset_req_o <= 1'b0;
        end else if (clear_i || restart_i) begin
            armed_q     <= 1'b0;
            dly_q       <= '0;
            reset_req_o <= 1'b0;
        end else if (ce_i) begin
            reset_req_o <= 1'b0;
            if (timeout_o && !armed_q) begin
                armed_q <= 1'b1;
                dly_q   <= 10'(RESET_DELAY - 1);
            end else if (armed_q) begin
                if (dly_q == 10'h000) begin
                    armed_q     <= 1'b0;
                    reset_req_o <= rst_en_i;
                end else begin
                    dly_q <= dly_q - 10'h001;
                end
            end
        end else begin
            reset_req_o <= 1'b0;
        end
    end
endmodule : wdt_core

// File: test/idle_powerdown_reset_control_asserts.sv
// Purpose: Port-level checks of idle, power-down and reset timing
// Assumes: Clock enable held high
// Notes:   Bounds allow for the pin synchroniser and sampling phase
module idle_powerdown_reset_control_asserts
    import pwr_rst_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       reset_pin_i,
    input wire logic       we_i,
    input wire logic       irq_req_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       cpu_clk_en_o,
    input wire logic       periph_clk_en_o,
    input wire logic       cpu_reset_o,
    input wire logic       ale_o,
    input wire logic       program_store_strobe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Idle request while running, no wake pending
    sequence idle_req;
        we_i && addr_i == ADDR_PWRC && wdata_i == 8'h01 && cpu_clk_en_o && !cpu_reset_o
            && !irq_req_i ##1 !irq_req_i;
    endsequence
    sequence pin_low;
        !reset_pin_i [*4];
    endsequence
    a_idle_entry: assert property (idle_req |=> !cpu_clk_en_o)
        else $error("idle not entered");
    a_idle_strobes: assert property (!cpu_clk_en_o && periph_clk_en_o && !cpu_reset_o
        |-> ale_o && program_store_strobe_o) else $error("idle strobes low");
    a_pd_strobes: assert property (!periph_clk_en_o && !cpu_reset_o
        |-> !ale_o && !program_store_strobe_o) else $error("pd strobes high");
    a_irq_wake: assert property (!cpu_clk_en_o && periph_clk_en_o && !cpu_reset_o
        && irq_req_i |-> ##2 cpu_clk_en_o) else $error("idle wake late");
    a_pin_reset: assert property (reset_pin_i [*8] |-> ##[0:3] cpu_reset_o)
        else $error("pin reset missed");
    a_reset_stays: assert property (reset_pin_i && cpu_reset_o |=> cpu_reset_o)
        else $error("reset left early");
    a_reset_release: assert property ($fell(reset_pin_i) |-> ##[1:20] !cpu_reset_o)
        else $error("reset not released");
    a_reset_long: assert property ($rose(cpu_reset_o) |-> cpu_reset_o [*8])
        else $error("reset too short");
    a_pd_quiet: assert property (pin_low ##0 (!periph_clk_en_o && !cpu_reset_o)
        |=> !cpu_reset_o) else $error("reset in pd");
endmodule : idle_powerdown_reset_control_asserts

bind idle_powerdown_reset_control idle_powerdown_reset_control_asserts i_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reset_pin_i(reset_pin_i), .we_i(we_i),
    .irq_req_i(irq_req_i), .addr_i(addr_i), .wdata_i(wdata_i), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .cpu_reset_o(cpu_reset_o), .ale_o(ale_o),
    .program_store_strobe_o(program_store_strobe_o));

// File: test/pin_source.sv
// Purpose: Far-side model of the reset pin and external interrupt pins
// Assumes: Reset requests arrive as one-cycle pulses, interrupt requests as levels from the bench
// Notes:   Reset pulse never shorter than two machine cycles
module pin_source (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] hold_i,
    input  wire logic       int0_req_i,
    output logic            reset_pin_o,
    output logic            int0_n_o,
    output logic            int1_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    // Short requests are stretched, a real source must hold 8 clocks
    always @(posedge clk_i) begin
        if (go_i) cnt <= (hold_i < 8) ? 8 : int'(hold_i);
        else if (cnt > 0) cnt <= cnt - 1;
    end
    assign reset_pin_o = (cnt > 0);
    // Level held low until the bench sees the wake
    assign int0_n_o = !int0_req_i;
    assign int1_n_o = 1'b1;
endmodule : pin_source

// File: test/testbench.sv
// Purpose: Self-checking bench for idle, power-down and reset sequencing
// Assumes: Internal program memory, clock enable always high
// Notes:   Reads are scored from a queue of notes by a monitor
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import pwr_rst_pkg::*;
    logic clk_i = 0, rst_n_i = 0, we = 0, re = 0, irq = 0, go = 0, i0 = 0, rv = 0;
    logic ale_c = 1, pss_c = 1, rpin, i0n, i1n, cen, pen, crst, ale, pss, oe;
    logic [7:0] adr = 0, wd = 0, p0r = 0, p2r = 0, lo = 0, hi = 0, hold = 8;
    logic [7:0] rdata, p0, p2, p2_old, p0_hold;
    logic [15:0] exp_q[$], e;
    int errors = 0, tests_run = 0;
    idle_powerdown_reset_control #(.WDT_BITS(4), .POR_DELAY(4)) i_idle_powerdown_reset_control (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .reset_pin_i(rpin),
        .int0_n_i(i0n), .int1_n_i(i1n), .ext_prog_i(1'b0), .irq_req_i(irq),
        .ale_cpu_i(ale_c), .prog_store_strobe_cpu_i(pss_c), .port0_reg_i(p0r),
        .port2_reg_i(p2r), .bus_lo_i(lo), .bus_lo_oe_i(1'b0), .addr_hi_i(hi),
        .addr_i(adr), .wdata_i(wd), .we_i(we), .re_i(re), .rdata_o(rdata),
        .cpu_clk_en_o(cen), .periph_clk_en_o(pen), .cpu_reset_o(crst), .ale_o(ale),
        .program_store_strobe_o(pss), .port0_o(p0), .port0_oe_o(oe), .port2_o(p2));
    pin_source i_pin_source (.clk_i(clk_i), .go_i(go), .hold_i(hold), .int0_req_i(i0),
        .reset_pin_o(rpin), .int0_n_o(i0n), .int1_n_o(i1n));
    initial forever #2 clk_i = ~clk_i;
    // Core strobes and buses wander so pass-through is exercised
    always @(posedge clk_i) {ale_c, pss_c, lo, hi, p0r} <= 26'($urandom);
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        tests_run++;
        if (s !== x) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic cy(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cy
    // Bounded wait on a level, settled values only
    task automatic wt(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) @(negedge clk_i);
        if (s !== v) begin
            errors++;
            $display("[ERR] %0t wait ran out", $time);
            end_of_test();
        end
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) {adr, wd, we} <= {a, d, 1'b1};
        @(posedge clk_i) we <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        @(posedge clk_i) {adr, re} <= {a, 1'b1};
        exp_q.push_back({m, x});
        @(posedge clk_i) re <= 0;
    endtask : rd
    task automatic pulse_rst;
        @(posedge clk_i) {hold, go} <= {8'(8 + $urandom % 16), 1'b1};
        @(posedge clk_i) go <= 0;
    endtask : pulse_rst
    // Data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        rv <= re;
        if (rv) begin
            e = exp_q.pop_front();
            chk(rdata & e[15:8], e[7:0]);
        end
    end
    initial begin
        void'($urandom(82402));
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1;
        wt(crst, 0, 40);
        rd(ADDR_WDCTL, 8'hF7, 8'h70);
        rd(ADDR_PWRC, 8'hFF, 8'h00);
        rd(8'h10, 8'hFF, 8'h00);
        wr(ADDR_WDCTL, 8'h00);
        rd(ADDR_WDCTL, 8'h40, 8'h00);
        $display("reset values done");
        p2_old = 8'($urandom);
        p2r <= p2_old;
        wr(ADDR_PWRC, 8'h01);
        cy(2);
        chk(cen, 0);
        chk(pen, 1);
        chk({ale, pss}, 2'b11);
        p0_hold = p0;
        @(posedge clk_i) p2r <= ~p2_old;
        cy(3);
        chk(p2, p2_old);
        chk(p0, p0_hold);
        rd(ADDR_PWRC, 8'h03, 8'h01);
        @(posedge clk_i) irq <= 1;
        @(posedge clk_i) irq <= 0;
        cy(2);
        chk(cen, 1);
        rd(ADDR_PWRC, 8'h03, 8'h00);
        wr(ADDR_PWRC, 8'h01);
        cy(3);
        pulse_rst();
        wt(crst, 1, 40);
        wt(crst, 0, 80);
        rd(ADDR_PWRC, 8'h03, 8'h00);
        rd(ADDR_WDCTL, 8'h44, 8'h00);
        $display("idle done");
        wr(ADDR_WDCTL, 8'h03);
        wr(ADDR_PWRC, 8'h01);
        wt(crst, 1, 700);
        wt(crst, 0, 20);
        rd(ADDR_WDCTL, 8'h46, 8'h06);
        rd(ADDR_PWRC, 8'h03, 8'h00);
        $display("watchdog done");
        wr(ADDR_INTCFG, 8'h01);
        wr(ADDR_WDCTL, 8'h03);
        wr(ADDR_PWRC, 8'h02);
        cy(2);
        chk(pen, 0);
        chk({ale, pss, oe}, 3'b001);
        chk(p2, p2r);
        i0 <= 1;
        cy(700);
        chk(crst, 0);
        chk(pen, 0);
        wr(ADDR_INTCFG, 8'h85);
        cy(8);
        chk(pen, 0);
        wr(ADDR_INTCFG, 8'h81);
        wt(pen, 1, 20);
        i0 <= 0;
        rd(ADDR_PWRC, 8'h03, 8'h00);
        wr(ADDR_WDCTL, 8'h03);
        wr(ADDR_PWRC, 8'h02);
        cy(4);
        pulse_rst();
        wt(crst, 1, 30);
        wt(crst, 0, 80);
        chk(pen, 1);
        rd(ADDR_PWRC, 8'h03, 8'h00);
        $display("power-down done");
        cy(4);
        end_of_test();
    end
endmodule : testbench
